/* logic/tsa_top.sv */
/*
  Two-wire slave: byte data register, own address and mask, address match,
  job-done and write-collision flags, interrupts, AXI4-Lite register slave.
  Assumes open-drain pads outside resolve the lines from the enables.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
// Functional notes
// - Data register holds next byte to send, or the last byte received.
// - Processor writes to data register land only while job-done flag is set.
// - Bus shifting leaves the data register unchanged while the job-done flag is set.
// - Shifting out a byte shifts the sampled bus value in, bit by bit.
// - Data register always shows last bus byte; no sleep mode here.
// - Master-to-slave switch on lost arbitration keeps the shifted byte intact.
// - Acknowledge bit is handled by the engine, never seen in data register.
// - Own address in bits 7:1, resets to ones, used in slave modes.
// - Bit 0 of own address enables general call address recognition.
// - Comparator checks received address; a match raises an interrupt request.
// - Mask bits 7:1, reset zero, exclude set bits from the comparison.
// - Mask register bit 0 is read-only zero.
// - Job-done set when job finishes; write one clears and resumes the bus.
// - Write collision set on data write while job-done low, cleared otherwise.
`include "tsa_consts.svh"
`timescale 1ns/100ps

module tsa_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output tsa_pkg::tsa_resp_t s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output tsa_pkg::tsa_resp_t s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Two-wire bus lines
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Interrupt
   output logic irq
);
   import tsa_pkg::*;

   logic [1:0] rstSyncR;
   logic rstN;
   logic sdaLvl;
   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;

   // Bus slave state
   logic awHeldR, awHeld_nxt;
   logic wHeldR, wHeld_nxt;
   logic [11:0] awAddrR, awAddr_nxt;
   logic [7:0] wByteR, wByte_nxt;
   logic wLaneR, wLane_nxt;
   logic bvalidR, bvalid_nxt;
   tsa_resp_t brespR, bresp_nxt;
   logic rvalidR, rvalid_nxt;
   logic [7:0] rdataR, rdata_nxt;
   tsa_resp_t rrespR, rresp_nxt;

   // Register and engine state
   logic [7:0] ownR, own_nxt;
   logic [7:1] maskR, mask_nxt;
   logic [7:0] dataR, data_nxt;
   logic doneR, done_nxt;
   logic ackEnR, ackEn_nxt;
   logic wcolR, wcol_nxt;
   logic enR, en_nxt;
   logic [`TSA_EV_W-1:0] istR, ist_nxt;
   logic [`TSA_EV_W-1:0] imaskR, imask_nxt;
   tsa_state_t stateR, state_nxt;
   logic [2:0] bitCntR, bitCnt_nxt;
   logic sampleR, sample_nxt;
   logic sampleValidR, sampleValid_nxt;
   logic addressedR, addressed_nxt;
   logic gcallR, gcall_nxt;
   logic xmitR, xmit_nxt;
   logic nackR, nack_nxt;

   // Decode helpers
   logic doWrite;
   logic [9:0] wrIdx;
   logic wrHit;
   logic rdHit;
   logic [7:0] rdMux;
   logic [7:0] shifted;
   logic ownMatch;
   logic gcMatch;
   logic [`TSA_EV_W-1:0] events;

   // Reset released through two flops; the rest of the design uses the copy
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rstSyncR <= 2'h0;
      end else begin
         rstSyncR <= {rstSyncR[0], 1'b1};
      end
   end
   assign rstN = rstSyncR[1];

   tsa_line_sync u_line (
      .mclk(mclk),
      .rstN(rstN),
      .sclIn(sclIn),
      .sdaIn(sdaIn),
      .sclLvl(),
      .sdaLvl(sdaLvl),
      .sclRise(sclRise),
      .sclFall(sclFall),
      .startDet(startDet),
      .stopDet(stopDet)
   );

   // Handshakes; one write and one read under way at a time
   assign s_axi_awready = ~awHeldR & ~bvalidR;
   assign s_axi_wready = ~wHeldR & ~bvalidR;
   assign s_axi_arready = ~rvalidR;
   assign s_axi_bvalid = bvalidR;
   assign s_axi_bresp = brespR;
   assign s_axi_rvalid = rvalidR;
   assign s_axi_rresp = rrespR;
   assign s_axi_rdata = {24'h000000, rdataR};

   assign doWrite = awHeldR & wHeldR & ~bvalidR;
   assign wrIdx = awAddrR[11:2];
   assign wrHit = (wrIdx == `TSA_IDX_OWN) | (wrIdx == `TSA_IDX_MASK) | (wrIdx == `TSA_IDX_DATA) |
                  (wrIdx == `TSA_IDX_CTRL) | (wrIdx == `TSA_IDX_STAT) | (wrIdx == `TSA_IDX_ISTAT) |
                  (wrIdx == `TSA_IDX_IMASK);

   // Read mux; unmapped reads return zero with an error
   always_comb begin
      rdHit = 1'b1;
      unique case (s_axi_araddr[11:2])
         `TSA_IDX_OWN: rdMux = ownR;
         `TSA_IDX_MASK: rdMux = {maskR, 1'b0};
         `TSA_IDX_DATA: rdMux = dataR;
         `TSA_IDX_CTRL: rdMux = {doneR, ackEnR, 2'h0, wcolR, enR, 2'h0};
         `TSA_IDX_STAT: rdMux = {4'h0, nackR, xmitR, gcallR, addressedR};
         `TSA_IDX_ISTAT: rdMux = {5'h00, istR};
         `TSA_IDX_IMASK: rdMux = {5'h00, imaskR};
         default: begin
            rdMux = 8'h00;
            rdHit = 1'b0;
         end
      endcase
   end

   // Bus channel next state
   always_comb begin
      awHeld_nxt = awHeldR;
      wHeld_nxt = wHeldR;
      awAddr_nxt = awAddrR;
      wByte_nxt = wByteR;
      wLane_nxt = wLaneR;
      bvalid_nxt = bvalidR;
      bresp_nxt = brespR;
      rvalid_nxt = rvalidR;
      rdata_nxt = rdataR;
      rresp_nxt = rrespR;
      if (s_axi_awvalid && s_axi_awready) begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeld_nxt = 1'b1;
         wByte_nxt = s_axi_wdata[7:0];
         wLane_nxt = s_axi_wstrb[0];
      end
      if (bvalidR && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (doWrite) begin
         awHeld_nxt = 1'b0;
         wHeld_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rdMux;
         rresp_nxt = rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalidR && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         awHeldR <= 1'b0;
         wHeldR <= 1'b0;
         awAddrR <= 12'h000;
         wByteR <= 8'h00;
         wLaneR <= 1'b0;
         bvalidR <= 1'b0;
         brespR <= RESP_OKAY;
         rvalidR <= 1'b0;
         rdataR <= 8'h00;
         rrespR <= RESP_OKAY;
      end else begin
         awHeldR <= awHeld_nxt;
         wHeldR <= wHeld_nxt;
         awAddrR <= awAddr_nxt;
         wByteR <= wByte_nxt;
         wLaneR <= wLane_nxt;
         bvalidR <= bvalid_nxt;
         brespR <= bresp_nxt;
         rvalidR <= rvalid_nxt;
         rdataR <= rdata_nxt;
         rrespR <= rresp_nxt;
      end
   end

   // Address compare on the byte as it completes; direction bit left out
   assign shifted = {dataR[6:0], sampleR};
   assign ownMatch = (((shifted[7:1] ^ ownR[7:1]) & ~maskR) == 7'h00);
   assign gcMatch = ownR[0] & (shifted[7:1] == `TSA_GCALL_ADDR);

   // Engine and register file next state
   always_comb begin
      own_nxt = ownR;
      mask_nxt = maskR;
      data_nxt = dataR;
      done_nxt = doneR;
      ackEn_nxt = ackEnR;
      wcol_nxt = wcolR;
      en_nxt = enR;
      ist_nxt = istR;
      imask_nxt = imaskR;
      state_nxt = stateR;
      bitCnt_nxt = bitCntR;
      sample_nxt = sampleR;
      sampleValid_nxt = sampleValidR;
      addressed_nxt = addressedR;
      gcall_nxt = gcallR;
      xmit_nxt = xmitR;
      nack_nxt = nackR;
      events = '0;
      // Software writes; only byte lane 0 carries register bits
      if (doWrite && wLaneR) begin
         unique case (wrIdx)
            `TSA_IDX_OWN: own_nxt = wByteR;
            `TSA_IDX_MASK: mask_nxt = wByteR[7:1];
            `TSA_IDX_DATA: begin
               if (doneR) begin
                  data_nxt = wByteR;
                  wcol_nxt = 1'b0;
               end else begin
                  wcol_nxt = 1'b1;
                  events[`TSA_EV_WCOL] = 1'b1;
               end
            end
            `TSA_IDX_CTRL: begin
               ackEn_nxt = wByteR[`TSA_CTRL_ACKEN];
               en_nxt = wByteR[`TSA_CTRL_EN];
               if (wByteR[`TSA_CTRL_DONE]) begin
                  done_nxt = 1'b0;
               end
            end
            `TSA_IDX_ISTAT: ist_nxt = istR & ~wByteR[`TSA_EV_W-1:0];
            `TSA_IDX_IMASK: imask_nxt = wByteR[`TSA_EV_W-1:0];
            default: ;
         endcase
      end
      // Byte engine; frozen while the job-done flag holds the bus
      if (!enR) begin
         state_nxt = ST_IDLE;
         sampleValid_nxt = 1'b0;
         addressed_nxt = 1'b0;
      end else if (startDet) begin
         state_nxt = ST_ADDR;
         bitCnt_nxt = 3'h0;
         sampleValid_nxt = 1'b0;
         addressed_nxt = 1'b0;
         gcall_nxt = 1'b0;
      end else if (stopDet) begin
         state_nxt = ST_IDLE;
         events[`TSA_EV_STOP] = addressedR;
         addressed_nxt = 1'b0;
      end else if (!doneR) begin
         if (sclRise && stateR != ST_IDLE) begin
            sample_nxt = sdaLvl;
            sampleValid_nxt = 1'b1;
         end
         if (sclFall && sampleValidR) begin
            sampleValid_nxt = 1'b0;
            unique case (stateR)
               ST_IDLE: ;
               ST_ADDR, ST_RX, ST_TX: begin
                  // One register shifts both ways, so the byte survives any mode change
                  data_nxt = shifted;
                  bitCnt_nxt = bitCntR + 3'h1;
                  if (bitCntR == `TSA_LAST_BIT) begin
                     if (stateR == ST_ADDR) begin
                        if (ackEnR && (ownMatch || gcMatch)) begin
                           state_nxt = ST_ADDR_ACK;
                           addressed_nxt = 1'b1;
                           gcall_nxt = gcMatch & ~ownMatch;
                           xmit_nxt = shifted[0];
                        end else begin
                           state_nxt = ST_IDLE;
                        end
                     end else if (stateR == ST_RX) begin
                        state_nxt = ST_RX_ACK;
                     end else begin
                        state_nxt = ST_TX_ACK;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  done_nxt = 1'b1;
                  events[`TSA_EV_DONE] = 1'b1;
                  nack_nxt = 1'b0;
                  state_nxt = xmitR ? ST_TX : ST_RX;
               end
               ST_RX_ACK: begin
                  // Acknowledge kept out of the data register
                  done_nxt = 1'b1;
                  events[`TSA_EV_DONE] = 1'b1;
                  nack_nxt = ~ackEnR;
                  state_nxt = ST_RX;
               end
               ST_TX_ACK: begin
                  done_nxt = 1'b1;
                  events[`TSA_EV_DONE] = 1'b1;
                  nack_nxt = sampleR;
                  state_nxt = sampleR ? ST_IDLE : ST_TX;
                  addressed_nxt = ~sampleR;
               end
            endcase
         end
      end
      // Sticky events; a set in the clearing cycle wins
      ist_nxt = ist_nxt | events;
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         ownR <= `TSA_OWN_RST;
         maskR <= 7'(`TSA_MASK_RST >> 1);
         dataR <= `TSA_DATA_RST;
         doneR <= 1'b0;
         ackEnR <= 1'b0;
         wcolR <= 1'b0;
         enR <= 1'b0;
         istR <= '0;
         imaskR <= `TSA_IMASK_RST;
         stateR <= ST_IDLE;
         bitCntR <= 3'h0;
         sampleR <= 1'b1;
         sampleValidR <= 1'b0;
         addressedR <= 1'b0;
         gcallR <= 1'b0;
         xmitR <= 1'b0;
         nackR <= 1'b0;
      end else begin
         ownR <= own_nxt;
         maskR <= mask_nxt;
         dataR <= data_nxt;
         doneR <= done_nxt;
         ackEnR <= ackEn_nxt;
         wcolR <= wcol_nxt;
         enR <= en_nxt;
         istR <= ist_nxt;
         imaskR <= imask_nxt;
         stateR <= state_nxt;
         bitCntR <= bitCnt_nxt;
         sampleR <= sample_nxt;
         sampleValidR <= sampleValid_nxt;
         addressedR <= addressed_nxt;
         gcallR <= gcall_nxt;
         xmitR <= xmit_nxt;
         nackR <= nack_nxt;
      end
   end

   // Open-drain lines: only ever pull low; clock held low while the job-done flag is set and the slave is still addressed
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = enR & doneR & addressedR;
   assign sdaOe = enR & ((stateR == ST_ADDR_ACK) | ((stateR == ST_RX_ACK) & ackEnR) |
                         ((stateR == ST_TX) & ~dataR[7]));

   // Level interrupt while any unmasked event is pending
   assign irq = |(istR & imaskR);

endmodule : tsa_top

/* logic/tsa_consts.svh */
/*
  Offsets, field positions and reset values of the two-wire slave address/data block.
  Assumes it is included by bare name; byte address is the register index times four.
*/
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// Register indices (byte address = index * 4)
`define TSA_IDX_OWN 10'h0BA
`define TSA_IDX_MASK 10'h0BD
`define TSA_IDX_DATA 10'h0C0
`define TSA_IDX_CTRL 10'h0C1
`define TSA_IDX_STAT 10'h0C2
`define TSA_IDX_ISTAT 10'h0C3
`define TSA_IDX_IMASK 10'h0C4

// Byte addresses
`define TSA_ADDR_OWN ({`TSA_IDX_OWN, 2'b00})
`define TSA_ADDR_MASK ({`TSA_IDX_MASK, 2'b00})
`define TSA_ADDR_DATA ({`TSA_IDX_DATA, 2'b00})
`define TSA_ADDR_CTRL ({`TSA_IDX_CTRL, 2'b00})
`define TSA_ADDR_STAT ({`TSA_IDX_STAT, 2'b00})
`define TSA_ADDR_ISTAT ({`TSA_IDX_ISTAT, 2'b00})
`define TSA_ADDR_IMASK ({`TSA_IDX_IMASK, 2'b00})

// Reset values
`define TSA_OWN_RST 8'hFE
`define TSA_MASK_RST 8'h00
`define TSA_DATA_RST 8'hFF
`define TSA_IMASK_RST 3'h0

// Control register bit positions
`define TSA_CTRL_DONE 7
`define TSA_CTRL_ACKEN 6
`define TSA_CTRL_WCOL 3
`define TSA_CTRL_EN 2

// Status register bit positions
`define TSA_STAT_ADDRD 0
`define TSA_STAT_GCALL 1
`define TSA_STAT_XMIT 2
`define TSA_STAT_NACK 3

// Interrupt event bit positions and width
`define TSA_EV_DONE 0
`define TSA_EV_WCOL 1
`define TSA_EV_STOP 2
`define TSA_EV_W 3

// Bus constants
`define TSA_GCALL_ADDR 7'h00
`define TSA_LAST_BIT 3'h7

`endif

/* logic/tsa_pkg.sv */
/*
  Types of the two-wire slave address/data block: engine states and bus responses.
  Assumes the constants header is included by the design files that need it.
*/
package tsa_pkg;

   // Byte engine states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } tsa_state_t;

   // AXI response codes
   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_SLVERR = 2'h2
   } tsa_resp_t;

endpackage : tsa_pkg

/* logic/tsa_line_sync.sv */
/*
  Line front end: synchronises the clock and data lines of the two-wire bus and
  finds their edges and the start and stop conditions.
  Assumes both lines are asynchronous to mclk and idle high.
*/
`timescale 1ns/100ps

module tsa_line_sync (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstN,
   // Raw lines
   input wire logic sclIn,
   input wire logic sdaIn,
   // Conditioned lines and events
   output logic sclLvl,
   output logic sdaLvl,
   output logic sclRise,
   output logic sclFall,
   output logic startDet,
   output logic stopDet
);

   logic sclMetaR;
   logic sclSyncR;
   logic sclPrevR;
   logic sdaMetaR;
   logic sdaSyncR;
   logic sdaPrevR;

   // Two flops per line, then one more stage purely for edge finding
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         sclMetaR <= 1'b1;
         sclSyncR <= 1'b1;
         sclPrevR <= 1'b1;
         sdaMetaR <= 1'b1;
         sdaSyncR <= 1'b1;
         sdaPrevR <= 1'b1;
      end else begin
         sclMetaR <= sclIn;
         sclSyncR <= sclMetaR;
         sclPrevR <= sclSyncR;
         sdaMetaR <= sdaIn;
         sdaSyncR <= sdaMetaR;
         sdaPrevR <= sdaSyncR;
      end
   end

   // Start and stop only count while the clock line stays high on both samples
   assign sclLvl = sclSyncR;
   assign sdaLvl = sdaSyncR;
   assign sclRise = sclSyncR & ~sclPrevR;
   assign sclFall = ~sclSyncR & sclPrevR;
   assign startDet = sclSyncR & sclPrevR & sdaPrevR & ~sdaSyncR;
   assign stopDet = sclSyncR & sclPrevR & ~sdaPrevR & sdaSyncR;

endmodule : tsa_line_sync

/* verif/tsa_monitor.sv */
/*
  Checker for tsa_top: register bus handshakes, reset quiet state, line drives.
  Assumes it sees only the top ports; bound below the module.
*/
`timescale 1ns/100ps

module tsa_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire tsa_pkg::tsa_resp_t s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Lines and interrupt
   input wire logic sclOut,
   input wire logic sclOe,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic irq
);
   // All checks share one domain
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped or changed early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed early");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data wider than one byte");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write not answered in time");
   a_drive_low_only: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
      else $error("line driven high");
   // Stretch can only end by a register write, since start and stop need a high clock line
   a_stretch_release: assert property ($fell(sclOe) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("clock stretch ended without a write");
   a_reset_quiet: assert property ($rose(rstn) |-> !s_axi_bvalid && !s_axi_rvalid && !sclOe && !sdaOe && !irq)
      else $error("outputs active out of reset");
endmodule : tsa_monitor

bind tsa_top tsa_monitor u_tsa_monitor (.mclk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sclOut, .sclOe, .sdaOut, .sdaOe, .irq);

/* verif/tsa_bus_master.sv */
/*
  Behavioural master on the two-wire bus: start, stop, byte out, byte in.
  Assumes pull-ups resolve the lines outside; drives are high when released.
*/
`timescale 1ns/100ps

module tsa_bus_master (
   // Open-drain drives
   output logic sclDrive,
   output logic sdaDrive,
   // Resolved lines
   input wire logic sclLine,
   input wire logic sdaLine
);
   // Clock stands still high between frames
   initial begin
      sclDrive = 1'b1;
      sdaDrive = 1'b1;
   end

   // One bit of 80 ns; a stretched clock line delays the high phase
   task automatic bitXfer(input logic b, output logic s);
      #20 sdaDrive = b;
      #20 sclDrive = 1'b1;
      wait (sclLine === 1'b1);
      #20 s = sdaLine;
      #20 sclDrive = 1'b0;
   endtask : bitXfer

   task automatic startCond;
      #40 sdaDrive = 1'b0;
      #40 sclDrive = 1'b0;
   endtask : startCond

   task automatic stopCond;
      #20 sdaDrive = 1'b0;
      #20 sclDrive = 1'b1;
      wait (sclLine === 1'b1);
      #20 sdaDrive = 1'b1;
      #40;
   endtask : stopCond

   // Most significant bit first, then the slave's acknowledge
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitXfer(d[i], s);
      bitXfer(1'b1, ack);
   endtask : sendByte

   task automatic recvByte(input logic ackBit, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(1'b1, s);
         d[i] = s;
      end
      bitXfer(ackBit, s);
   endtask : recvByte
endmodule : tsa_bus_master

/* verif/tsa_tb_top.sv */
/*
  Bench for tsa_top: register tasks over AXI4-Lite and a bus master model.
  Assumes pull-ups on both lines and the design and model compiled first.
*/
`include "tsa_consts.svh"
`timescale 1ns/100ps

module tsa_tb_top;
   import tsa_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [31:0] s_axi_rdata;
   tsa_resp_t s_axi_bresp, s_axi_rresp;
   logic sclOut, sclOe, sdaOut, sdaOe, sclDrive, sdaDrive, sclIn, sdaIn, ack;
   logic [7:0] rxByte;
   int nMismatch = 0;
   int nChecks = 0;

   always #5 mclk = ~mclk;
   // Pull-up lines: low while any party pulls
   assign sclIn = sclDrive & ~sclOe;
   assign sdaIn = sdaDrive & ~sdaOe;

   tsa_top u_tsa_top (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe, .irq);
   tsa_bus_master u_tsa_bus_master (.sclDrive, .sdaDrive, .sclLine(sclIn), .sdaLine(sdaIn));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("BAD %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input tsa_resp_t er);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w) begin
         @(posedge mclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] e, input tsa_resp_t er);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, {24'h000000, e});
      check({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd

   // Bounded wait for the job-done interrupt
   task automatic waitIrq;
      for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge mclk);
      check({31'h0, irq}, 32'h1);
   endtask : waitIrq

   // Clear the event and hand the bus back
   task automatic handBack;
      wr(`TSA_ADDR_ISTAT, 8'h01, RESP_OKAY);
      wr(`TSA_ADDR_CTRL, 8'hC4, RESP_OKAY);
   endtask : handBack

   task automatic finish_test;
      if (nMismatch == 0 && nChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   // Watchdog well beyond the expected few microseconds
   initial begin
      #300000;
      nMismatch++;
      finish_test;
   end

   initial begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(`TSA_ADDR_OWN, 8'hFE, RESP_OKAY);
      // Lane 0 strobe low: write answered but register untouched
      s_axi_wstrb <= 4'hE;
      wr(`TSA_ADDR_OWN, 8'h00, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(`TSA_ADDR_OWN, 8'hFE, RESP_OKAY);
      rd(`TSA_ADDR_MASK, 8'h00, RESP_OKAY);
      rd(12'h000, 8'h00, RESP_SLVERR);
      wr(12'h000, 8'hFF, RESP_SLVERR);
      wr(`TSA_ADDR_MASK, 8'hFF, RESP_OKAY);
      rd(`TSA_ADDR_MASK, 8'hFE, RESP_OKAY);
      // Data write before any job is done must not land
      wr(`TSA_ADDR_DATA, 8'h5A, RESP_OKAY);
      rd(`TSA_ADDR_DATA, 8'hFF, RESP_OKAY);
      rd(`TSA_ADDR_CTRL, 8'h08, RESP_OKAY);
      check({31'h0, irq}, 32'h0);
      wr(`TSA_ADDR_IMASK, 8'h02, RESP_OKAY);
      check({31'h0, irq}, 32'h1);
      wr(`TSA_ADDR_ISTAT, 8'h02, RESP_OKAY);
      check({31'h0, irq}, 32'h0);
      // Address 0x35, low two address bits masked
      wr(`TSA_ADDR_MASK, 8'h06, RESP_OKAY);
      wr(`TSA_ADDR_OWN, 8'h6A, RESP_OKAY);
      wr(`TSA_ADDR_IMASK, 8'h01, RESP_OKAY);
      wr(`TSA_ADDR_CTRL, 8'h44, RESP_OKAY);
      u_tsa_bus_master.startCond;
      u_tsa_bus_master.sendByte(8'h6C, ack);
      check({31'h0, ack}, 32'h0);
      waitIrq;
      rd(`TSA_ADDR_CTRL, 8'hCC, RESP_OKAY);
      rd(`TSA_ADDR_STAT, 8'h01, RESP_OKAY);
      handBack;
      check({31'h0, irq}, 32'h0);
      u_tsa_bus_master.sendByte(8'hA5, ack);
      check({31'h0, ack}, 32'h0);
      waitIrq;
      rd(`TSA_ADDR_DATA, 8'hA5, RESP_OKAY);
      rd(`TSA_ADDR_DATA, 8'hA5, RESP_OKAY);
      wr(`TSA_ADDR_DATA, 8'h3C, RESP_OKAY);
      rd(`TSA_ADDR_CTRL, 8'hC4, RESP_OKAY);
      rd(`TSA_ADDR_DATA, 8'h3C, RESP_OKAY);
      handBack;
      u_tsa_bus_master.stopCond;
      // Stop while addressed leaves only the stop event pending
      rd(`TSA_ADDR_ISTAT, 8'h04, RESP_OKAY);
      // Mismatch in an unmasked bit is not acknowledged
      u_tsa_bus_master.startCond;
      u_tsa_bus_master.sendByte(8'h2A, ack);
      check({31'h0, ack}, 32'h1);
      u_tsa_bus_master.stopCond;
      // General call, enabled then disabled
      wr(`TSA_ADDR_OWN, 8'h6B, RESP_OKAY);
      u_tsa_bus_master.startCond;
      u_tsa_bus_master.sendByte(8'h00, ack);
      check({31'h0, ack}, 32'h0);
      waitIrq;
      rd(`TSA_ADDR_STAT, 8'h03, RESP_OKAY);
      handBack;
      u_tsa_bus_master.stopCond;
      wr(`TSA_ADDR_OWN, 8'h6A, RESP_OKAY);
      u_tsa_bus_master.startCond;
      u_tsa_bus_master.sendByte(8'h00, ack);
      check({31'h0, ack}, 32'h1);
      u_tsa_bus_master.stopCond;
      // Read direction: direction bit selects transmit, byte sent then echoed back in
      u_tsa_bus_master.startCond;
      u_tsa_bus_master.sendByte(8'h6B, ack);
      check({31'h0, ack}, 32'h0);
      waitIrq;
      wr(`TSA_ADDR_DATA, 8'hC3, RESP_OKAY);
      handBack;
      u_tsa_bus_master.recvByte(1'b1, rxByte);
      check({24'h000000, rxByte}, 32'h000000C3);
      u_tsa_bus_master.stopCond;
      rd(`TSA_ADDR_DATA, 8'hC3, RESP_OKAY);
      finish_test;
   end
endmodule : tsa_tb_top
